// ---- plcc_ctrl.sv ----
`timescale 1ns/1ps
`include "plcc_regs.svh"
// Contract
// (R1) Decode address and data from rising-edge counts
// (R2) Latch count after pin held high timeout
// (R3) Data registers 4 bits; counts above 16 address
// (R4) Counts 17 to 21 select addresses 1 to 5
// (R5) Counts 1 to 16 write addressed register
// (R6) Host sends address, pause, data, pause
// (R7) Repeated data bursts reuse the latched address
// (R8) Low past shutdown timeout disables all sinks
// (R9) First edge after shutdown selects address 1
// (R10) Shutdown resets every register to one
// (R11) Address 1 writes main and sub together
// (R12) Address 2 main only, address 3 sub only
// (R13) Address 4 range, address 5 low-current
// (R14) Range 1 to 3 uses main/sub levels
// (R15) Range 4 uses low-current register only
// (R16) Sixteen level codes, about 1 dB apart
// (R17) Level code 16 gives zero current
// (R18) Default range is 20 mA scale
// (R19) Tolerate edge bursts above 1 MHz
// (R20) Load switch default, pump on near dropout
// (R21) Pump starts 1.5X, steps to 2X
// (R22) Range codes 1:20, 2:30, 3:15, 4:low
// (R23) Low-current quartets select group and level
// (R24) Host high phases at least 50 ns
// (R25) Ignore counts above 21; clear counter on latch
// (R26) Waking edge counts toward first burst
module plcc_ctrl #(
   parameter int LATCH_CYCLES = `PLCC_LATCH_CYCLES,
   parameter int SHUTDOWN_CYCLES = `PLCC_SHUTDOWN_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control pin
   input wire logic ctrl_pin_i,
   // Dropout sensing, one bit per sink
   input wire logic [5:0] dropout_i,
   // Sink drive
   output plcc_pkg::plcc_drive_t main_drive_o,
   output plcc_pkg::plcc_drive_t sub_drive_o,
   output logic active_o,
   output plcc_pkg::plcc_pump_t pump_mode_o
);
   import plcc_pkg::*;

   localparam int TW = $clog2(LATCH_CYCLES > SHUTDOWN_CYCLES ?
                              LATCH_CYCLES + 1 : SHUTDOWN_CYCLES + 1);
   localparam logic [TW-1:0] LATCH_LAST = TW'(LATCH_CYCLES - 1);
   localparam logic [TW-1:0] SHUT_LAST = TW'(SHUTDOWN_CYCLES - 1);

   // Pin filter, timers and edge count
   logic [2:0] pin_sync;
   logic pin_level;
   logic pin_rise;
   logic [TW-1:0] high_timer;
   logic [TW-1:0] low_timer;
   logic latch_evt;
   logic shut_evt;
   logic awake;
   logic [4:0] edge_cnt;

   // Address, registers and write strobes
   logic [2:0] addr;
   logic [3:0] main_group_level;
   logic [3:0] sub_group_level;
   logic [3:0] full_scale_range;
   logic [3:0] trickle_level;
   logic [3:0] data_val;
   logic is_data;
   logic is_addr;
   logic wr_hit;
   logic wr_main;
   logic wr_sub;
   logic wr_range;
   logic wr_trickle;

   // Dropout filter and drive build
   logic [5:0] drop_vec;
   logic drop_prev;
   logic drop_rise;
   plcc_scale_t scale;
   plcc_drive_t next_main;
   plcc_drive_t next_sub;

   // Pass a stored 4-bit code through as the level; 16 is already stored as the zero-current code
   function automatic logic [3:0] code_level(input logic [3:0] code);
      code_level = code;
   endfunction

   // Second and third stages agree: the sample is trusted
   function automatic logic settled(input logic [2:0] stages);
      settled = (stages[1] == stages[2]);
   endfunction

   // Three-stage sampler; stage 0 is read only by stage 1
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_sync <= 3'h0;
      end else begin
         pin_sync <= {pin_sync[1:0], ctrl_pin_i};
      end
   end

   // Level changes only when stages 1 and 2 agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_level <= 1'b0;
      end else if (settled(pin_sync)) begin
         pin_level <= pin_sync[2];
      end
   end

   // One cycle per edge keeps 1 MHz bursts well within reach
   assign pin_rise = settled(pin_sync) && pin_sync[2] &&
                     !pin_level; // see (R19)

   // High-time counter runs only while the filtered pin is high
   always_ff @(posedge clk_i) begin
      if (rst_i || !pin_level || pin_rise) begin
         high_timer <= TW'(0);
      end else if (high_timer != LATCH_LAST) begin
         high_timer <= high_timer + TW'(1);
      end
   end

   assign latch_evt = pin_level && (high_timer == LATCH_LAST - TW'(1)) &&
                      (edge_cnt != 5'h00); // see (R2)

   always_ff @(posedge clk_i) begin
      if (rst_i || pin_level) begin
         low_timer <= TW'(0);
      end else if (low_timer != SHUT_LAST) begin
         low_timer <= low_timer + TW'(1);
      end
   end

   assign shut_evt = !pin_level && awake &&
                     (low_timer == SHUT_LAST - TW'(1)); // see (R8)

   // An edge in the shutdown cycle still wakes, else it would be lost
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         awake <= 1'b0;
      end else if (pin_rise) begin
         awake <= 1'b1; // see (R9)
      end else if (shut_evt) begin
         awake <= 1'b0; // see (R8)
      end
   end

   // Edge counter saturates so long bursts stay above the address range
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         edge_cnt <= 5'h00;
      end else if (shut_evt) begin
         edge_cnt <= {4'h0, pin_rise}; // see (R26)
      end else if (pin_rise) begin
         if (edge_cnt != `PLCC_CNT_SAT) begin
            edge_cnt <= edge_cnt + 5'h01; // see (R1) (R26)
         end
      end else if (latch_evt) begin
         edge_cnt <= 5'h00; // see (R25)
      end
   end

   assign is_data = (edge_cnt <= `PLCC_DATA_MAX); // see (R3) (R5)
   assign is_addr = (edge_cnt >= `PLCC_ADDR_MIN) &&
                    (edge_cnt <= `PLCC_ADDR_MAX); // see (R4) (R25)
   assign data_val = edge_cnt[3:0]; // 16 folds to code 0

   always_ff @(posedge clk_i) begin
      if (rst_i || shut_evt) begin
         addr <= `PLCC_ADDR_BOTH; // see (R9)
      end else if (latch_evt && is_addr) begin
         addr <= 3'(edge_cnt - `PLCC_DATA_MAX); // see (R4)
      end
   end

   // Write strobes; address 1 reaches both level registers
   assign wr_hit = latch_evt && is_data; // see (R5) (R7)
   assign wr_main = wr_hit && (addr == `PLCC_ADDR_BOTH ||
                               addr == `PLCC_ADDR_MAIN); // see (R11) (R12)
   assign wr_sub = wr_hit && (addr == `PLCC_ADDR_BOTH ||
                              addr == `PLCC_ADDR_SUB); // see (R11) (R12)
   assign wr_range = wr_hit && (addr == `PLCC_ADDR_RANGE); // see (R13)
   assign wr_trickle = wr_hit && (addr == `PLCC_ADDR_TRICKLE); // see (R13)

   // Address kept after a data write, so bursts may repeat
   always_ff @(posedge clk_i) begin
      if (rst_i || shut_evt) begin
         main_group_level <= `PLCC_REG_RESET; // see (R10)
      end else if (wr_main) begin
         main_group_level <= data_val;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || shut_evt) begin
         sub_group_level <= `PLCC_REG_RESET; // see (R10)
      end else if (wr_sub) begin
         sub_group_level <= data_val;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || shut_evt) begin
         full_scale_range <= `PLCC_REG_RESET; // see (R10) (R18)
      end else if (wr_range) begin
         full_scale_range <= data_val;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || shut_evt) begin
         trickle_level <= `PLCC_REG_RESET; // see (R10)
      end else if (wr_trickle) begin
         trickle_level <= data_val;
      end
   end

   // Unlisted range codes fall back to the 20 mA scale
   always_comb begin
      unique case (full_scale_range) // see (R22)
         `PLCC_RANGE_30MA: scale = PLCC_FS_30MA;
         `PLCC_RANGE_15MA: scale = PLCC_FS_15MA;
         `PLCC_RANGE_TRICKLE: scale = PLCC_FS_TRICKLE;
         default: scale = PLCC_FS_20MA;
      endcase
   end

   // Trickle level field: 1-4 off, 5-8 sub, 9-12 main, 13-16 both; step 1..4 within quartet for 0.05/0.5/1/2 mA
   always_comb begin
      next_main.scale = scale;
      next_sub.scale = scale;
      if (scale == PLCC_FS_TRICKLE) begin // see (R15)
         // Level is the step within the quartet
         next_main.level = 4'(trickle_level[1:0] - 2'h1) + 4'h1;
         next_sub.level = next_main.level;
         unique case (2'(({1'b0, trickle_level} - 5'h01) >> 2)) // see (R23)
            2'h0: begin
               next_main.enable = 1'b0;
               next_sub.enable = 1'b0;
            end
            2'h1: begin
               next_main.enable = 1'b0;
               next_sub.enable = 1'b1;
            end
            2'h2: begin
               next_main.enable = 1'b1;
               next_sub.enable = 1'b0;
            end
            2'h3: begin
               next_main.enable = 1'b1;
               next_sub.enable = 1'b1;
            end
         endcase
      end else begin
         next_main.level = code_level(main_group_level); // see (R14) (R16)
         next_sub.level = code_level(sub_group_level);
         next_main.enable = (main_group_level != `PLCC_LEVEL_OFF); // see (R17)
         next_sub.enable = (sub_group_level != `PLCC_LEVEL_OFF);
      end
      if (!awake) begin
         next_main.enable = 1'b0;
         next_sub.enable = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         main_drive_o <= '0;
      end else begin
         main_drive_o <= next_main;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sub_drive_o <= '0;
      end else begin
         sub_drive_o <= next_sub;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         active_o <= 1'b0;
      end else begin
         active_o <= awake;
      end
   end

   // Each sink flag is analog: own three-stage filter before the OR
   for (genvar g = 0; g < 6; g++) begin : g_drop
      logic [2:0] stage;
      logic level;
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            stage <= 3'h0;
         end else begin
            stage <= {stage[1:0], dropout_i[g]};
         end
      end
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            level <= 1'b0;
         end else if (settled(stage)) begin
            level <= stage[2];
         end
      end
      assign drop_vec[g] = level;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drop_prev <= 1'b0;
      end else begin
         drop_prev <= |drop_vec;
      end
   end

   // New dropout on any sink after all were clear
   assign drop_rise = (|drop_vec) && !drop_prev;

   // Mode only climbs while awake; shutdown returns to load switch
   always_ff @(posedge clk_i) begin
      if (rst_i || !awake) begin
         pump_mode_o <= PLCC_PUMP_1X;
      end else if (drop_rise) begin
         unique case (pump_mode_o)
            PLCC_PUMP_1X: pump_mode_o <= PLCC_PUMP_1P5X; // see (R20) (R21)
            PLCC_PUMP_1P5X: pump_mode_o <= PLCC_PUMP_2X; // see (R21)
            PLCC_PUMP_2X: pump_mode_o <= PLCC_PUMP_2X;
            default: pump_mode_o <= PLCC_PUMP_1X;
         endcase
      end
   end

endmodule

// ---- plcc_ctrl_test.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module plcc_ctrl_test;
   import plcc_pkg::*;
   localparam int LAT = 40;
   localparam int SHD = 40;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [5:0] dropout_i = 6'h00;
   logic pin;
   plcc_drive_t main_o;
   plcc_drive_t sub_o;
   logic act;
   plcc_pump_t pump;
   int errors = 0;
   int checked = 0;
   int m = 1, s = 1, r = 1, t = 1, ca = 1;
   always #25 clk_i = ~clk_i;
   plcc_host #(.LATCH_CYCLES(LAT)) host_u (.clk_i(clk_i), .pin_o(pin));
   plcc_ctrl #(.LATCH_CYCLES(LAT), .SHUTDOWN_CYCLES(SHD)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .ctrl_pin_i(pin), .dropout_i(dropout_i),
      .main_drive_o(main_o), .sub_drive_o(sub_o), .active_o(act),
      .pump_mode_o(pump));
   function automatic plcc_drive_t ex(input int c, input bit mn);
      int q;
      q = (t - 1) / 4;
      if (r == 4)
         return (mn ? q >= 2 : q[0]) ? {1'b1, 2'h3, 4'(((t - 1) % 4) + 1)}
            : 7'h00;
      return {c != 16, (r == 2) ? 2'h1 : (r == 3) ? 2'h2 : 2'h0, 4'(c % 16)};
   endfunction
   // Disabled groups only promise a low enable bit
   task automatic chk;
      plcc_drive_t em, es;
      em = ex(m, 1'b1);
      es = ex(s, 1'b0);
      if (em.enable) `CHK(main_o, em) else `CHK(main_o.enable, 1'b0)
      if (es.enable) `CHK(sub_o, es) else `CHK(sub_o.enable, 1'b0)
   endtask
   // Address 0 means keep the latched address
   task automatic wr(input int a, input int d, input bit slow);
      if (a > 0) begin
         ca = a;
         host_u.send(a + 16, slow);
      end
      host_u.send(d, slow);
      case (ca)
         1: begin m = d; s = d; end
         2: m = d;
         3: s = d;
         4: r = d;
         default: t = d;
      endcase
   endtask
   task automatic finish_test;
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      #2000000;
      errors++;
      finish_test;
   end
   initial begin
      repeat (20) @(negedge clk_i);
      rst_i = 1'b0;
      @(negedge clk_i);
      `CHK(act, 1'b0)
      wr(0, 1, 1'b0);
      `CHK(act, 1'b1)
      chk;
      wr(3, 5, 1'b1);
      chk;
      wr(0, 7, 1'b0);
      chk;
      wr(2, 16, 1'b0);
      chk;
      wr(1, 3, 1'b0);
      chk;
      for (int i = 1; i <= 4; i++) begin
         wr(4, i, 1'b0);
         chk;
      end
      for (int c = 3; c <= 15; c += 4) begin
         wr(5, c, 1'b0);
         chk;
      end
      host_u.send(25, 1'b0);
      chk;
      wr(0, 14, 1'b0);
      chk;
      for (int i = 1; i < 3; i++) begin
         dropout_i = 6'h04;
         repeat (6) @(negedge clk_i);
         dropout_i = 6'h00;
         repeat (6) @(negedge clk_i);
         `CHK(pump, plcc_pump_t'(i))
      end
      host_u.park(SHD + 10);
      `CHK(act, 1'b0)
      `CHK(main_o.enable | sub_o.enable, 1'b0)
      `CHK(pump, PLCC_PUMP_1X)
      m = 1; s = 1; r = 1; t = 1; ca = 1;
      wr(0, 2, 1'b0);
      chk;
      finish_test;
   end
endmodule
bind plcc_ctrl plcc_props #(.LATCH_CYCLES(LATCH_CYCLES),
   .SHUTDOWN_CYCLES(SHUTDOWN_CYCLES)) props_u (.clk_i(clk_i), .rst_i(rst_i),
   .ctrl_pin_i(ctrl_pin_i), .dropout_i(dropout_i),
   .main_drive_o(main_drive_o), .sub_drive_o(sub_drive_o),
   .active_o(active_o), .pump_mode_o(pump_mode_o));

// ---- plcc_host.sv ----
`timescale 1ns/1ps
module plcc_host #(
   parameter int LATCH_CYCLES = 40
) (
   // Clock
   input wire logic clk_i,
   // Control pin
   output logic pin_o
);
   initial pin_o = 1'b0;
   // Burst of n edges, then hold high long enough to commit
   task automatic send(input int n, input bit slow);
      int ph;
      ph = slow ? 12 : 4;
      repeat (n) begin
         pin_o = 1'b0;
         repeat (ph) @(negedge clk_i);
         pin_o = 1'b1;
         repeat (ph) @(negedge clk_i);
      end
      repeat (LATCH_CYCLES + 8) @(negedge clk_i);
   endtask
   task automatic park(input int n);
      pin_o = 1'b0;
      repeat (n) @(negedge clk_i);
   endtask
endmodule

// ---- plcc_pkg.sv ----
package plcc_pkg;

   typedef enum logic [1:0] {
      PLCC_PUMP_1X,
      PLCC_PUMP_1P5X,
      PLCC_PUMP_2X
   } plcc_pump_t;

   typedef enum logic [1:0] {
      PLCC_FS_20MA,
      PLCC_FS_30MA,
      PLCC_FS_15MA,
      PLCC_FS_TRICKLE
   } plcc_scale_t;

   // Drive for one sink group: scale plus level or trickle step
   typedef struct packed {
      logic enable;
      plcc_scale_t scale;
      logic [3:0] level;
   } plcc_drive_t;

endpackage

// ---- plcc_props.sv ----
`timescale 1ns/1ps
module plcc_props #(
   parameter int LATCH_CYCLES = 40,
   parameter int SHUTDOWN_CYCLES = 40
) (
   // Clock, reset and pins
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ctrl_pin_i,
   input wire logic [5:0] dropout_i,
   // Device outputs
   input plcc_pkg::plcc_drive_t main_drive_o,
   input plcc_pkg::plcc_drive_t sub_drive_o,
   input wire logic active_o,
   input plcc_pkg::plcc_pump_t pump_mode_o
);
   import plcc_pkg::*;
   logic [15:0] hi_cnt;
   logic [15:0] lo_cnt;
   // Raw pin run lengths; filter lag is allowed for in the bounds
   always_ff @(posedge clk_i) begin
      if (rst_i || !ctrl_pin_i) begin
         hi_cnt <= 16'h0000;
      end else if (hi_cnt != 16'hFFFF) begin
         hi_cnt <= hi_cnt + 16'h0001;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i || ctrl_pin_i) begin
         lo_cnt <= 16'h0000;
      end else if (lo_cnt != 16'hFFFF) begin
         lo_cnt <= lo_cnt + 16'h0001;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   reset_state_a: assert property ($fell(rst_i) |-> !active_o &&
      main_drive_o == 7'h00 && sub_drive_o == 7'h00 &&
      pump_mode_o == PLCC_PUMP_1X) else $error("reset state wrong");
   dark_when_off_a: assert property (!active_o && !$past(active_o) |->
      !main_drive_o.enable && !sub_drive_o.enable)
      else $error("sink on while shut down");
   shutdown_time_a: assert property (lo_cnt >= SHUTDOWN_CYCLES + 8 |->
      !active_o) else $error("no shutdown after long low");
   wake_on_edge_a: assert property (!active_o && $rose(ctrl_pin_i)
      |-> ##[1:8] active_o) else $error("no wake on edge");
   latch_timing_a: assert property (active_o && $past(active_o) &&
      (main_drive_o != $past(main_drive_o) ||
      sub_drive_o != $past(sub_drive_o)) |-> hi_cnt >= LATCH_CYCLES - 2
      && hi_cnt <= LATCH_CYCLES + 8) else $error("latch at wrong time");
   pump_start_a: assert property (active_o && $rose(|dropout_i) &&
      pump_mode_o == PLCC_PUMP_1X |-> ##[1:6] pump_mode_o == PLCC_PUMP_1P5X)
      else $error("pump did not start");
   pump_step_a: assert property (active_o && $past(active_o) &&
      pump_mode_o != $past(pump_mode_o) |->
      pump_mode_o == $past(pump_mode_o) + 2'h1) else $error("bad pump step");
   level_zero_off_a: assert property (main_drive_o.level == 4'h0 &&
      main_drive_o.scale != PLCC_FS_TRICKLE |-> !main_drive_o.enable)
      else $error("zero level enabled");
   cover property (main_drive_o.enable && main_drive_o.scale == PLCC_FS_TRICKLE);
   cover property (pump_mode_o == PLCC_PUMP_2X);
   cover property ($fell(active_o));
endmodule

// ---- plcc_regs.svh ----
`ifndef PLCC_REGS_SVH
`define PLCC_REGS_SVH

// Addresses carried by edge bursts
`define PLCC_ADDR_BOTH 3'h1
`define PLCC_ADDR_MAIN 3'h2
`define PLCC_ADDR_SUB 3'h3
`define PLCC_ADDR_RANGE 3'h4
`define PLCC_ADDR_TRICKLE 3'h5

// Edge count thresholds
`define PLCC_DATA_MAX 5'h10
`define PLCC_ADDR_MIN 5'h11
`define PLCC_ADDR_MAX 5'h15
`define PLCC_CNT_SAT 5'h1F

// Register reset value
`define PLCC_REG_RESET 4'h1

// Range codes
`define PLCC_RANGE_20MA 4'h1
`define PLCC_RANGE_30MA 4'h2
`define PLCC_RANGE_15MA 4'h3
`define PLCC_RANGE_TRICKLE 4'h4

// Level code that gives zero current
`define PLCC_LEVEL_OFF 4'h0

// Timing, microseconds, and clock rate in kHz
`define PLCC_LATCH_TIMEOUT_US 500
`define PLCC_SHUTDOWN_TIMEOUT_US 500
`define PLCC_CLK_KHZ 20000
`define PLCC_LATCH_CYCLES \
   ((`PLCC_LATCH_TIMEOUT_US * `PLCC_CLK_KHZ) / 1000)
`define PLCC_SHUTDOWN_CYCLES \
   ((`PLCC_SHUTDOWN_TIMEOUT_US * `PLCC_CLK_KHZ) / 1000)

`endif
